// ===== logic/scsr_status_top.sv
// Status reporting hierarchy: operation, questionable, event status, status byte
`timescale 1ns/10ps
module scsr_status_top import scsr_pkg::*; (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Instrument pins from outside the clock domain
  input wire logic calibrating,
  input wire logic [14:0] ques_cond,
  // Same-clock status sources
  input wire logic errq_not_empty,
  input wire logic msg_available,
  input wire logic [7:0] esr_event,
  // Command port from the remote-control interpreter
  input wire scsr_cmd_t cmd,
  output scsr_rsp_t rsp_q,
  // Status byte and service request
  output logic [7:0] stb_q,
  output logic srq_q
);

  //==============================================================
  // Pin synchronisers
  // Three stages; a change counts once stages two and three agree,
  // which also rejects a single-cycle glitch on the pins
  logic [15:0] pin_raw;
  logic [15:0] s1_q, s2_q, s3_q, filt_q, filt_d;

  assign pin_raw = {1'b0, ques_cond[14:1], ques_cond[0]} & {1'b1, 15'h7FFF};

  // Filter: follow stage three only where it agrees with stage two
  always_comb begin
    filt_d = (s2_q & s3_q) | (filt_q & (s2_q ^ s3_q));
  end

  // Synchroniser flops; stage one is read by stage two only
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= SCSR_ZERO16;
      s2_q <= SCSR_ZERO16;
      s3_q <= SCSR_ZERO16;
      filt_q <= SCSR_ZERO16;
    end else begin
      s1_q <= pin_raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      filt_q <= filt_d;
    end
  end

  // Calibration pin gets its own chain
  logic cal_s1_q, cal_s2_q, cal_s3_q, cal_q, cal_d;

  // Same agreement filter for the calibration pin
  always_comb begin
    cal_d = (cal_s2_q & cal_s3_q) | (cal_q & (cal_s2_q ^ cal_s3_q));
  end

  // Calibration synchroniser flops
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cal_s1_q <= 1'b0;
      cal_s2_q <= 1'b0;
      cal_s3_q <= 1'b0;
      cal_q <= 1'b0;
    end else begin
      cal_s1_q <= calibrating;
      cal_s2_q <= cal_s1_q;
      cal_s3_q <= cal_s2_q;
      cal_q <= cal_d;
    end
  end

  //==============================================================
  // Command decode
  logic rd, wr; // Read and write strobes
  logic [3:0] oper_off, ques_off; // Select relative to each base
  logic oper_hit, ques_hit;

  assign rd = cmd.valid & ~cmd.write;
  assign wr = cmd.valid & cmd.write;
  assign oper_off = cmd.sel - SCSR_SEL_OPER;
  assign ques_off = cmd.sel - SCSR_SEL_QUES;
  assign oper_hit = (cmd.sel >= SCSR_SEL_OPER) && (oper_off <= SCSR_PART_EN);
  assign ques_hit = (cmd.sel >= SCSR_SEL_QUES) && (ques_off <= SCSR_PART_EN);

  //==============================================================
  // Operation and questionable registers
  logic [15:0] oper_cond_in; // Live operation condition
  logic [15:0] op_cond, op_ptr, op_ntr, op_ev, op_en;
  logic [15:0] qu_cond, qu_ptr, qu_ntr, qu_ev, qu_en;
  logic oper_sum, ques_sum;

  // Only the calibration bit is in use; the rest stay zero
  always_comb begin
    oper_cond_in = SCSR_ZERO16;
    oper_cond_in[SCSR_OPER_CAL_BIT] = cal_q;
  end

  // Operation register
  scsr_status_reg u_oper (
    .clock(clock),
    .rst_n(rst_n),
    .cond_in(oper_cond_in),
    .wr_ptr(wr && oper_hit && oper_off == SCSR_PART_PTR),
    .wr_ntr(wr && oper_hit && oper_off == SCSR_PART_NTR),
    .wr_en(wr && oper_hit && oper_off == SCSR_PART_EN),
    .wr_data(cmd.data),
    .rd_event(rd && oper_hit && oper_off == SCSR_PART_EVENT),
    .cond_q(op_cond),
    .ptr_q(op_ptr),
    .ntr_q(op_ntr),
    .event_q(op_ev),
    .en_q(op_en),
    .sum_q(oper_sum)
  );

  // Questionable register, fed from the filtered pins
  scsr_status_reg u_ques (
    .clock(clock),
    .rst_n(rst_n),
    .cond_in(filt_q),
    .wr_ptr(wr && ques_hit && ques_off == SCSR_PART_PTR),
    .wr_ntr(wr && ques_hit && ques_off == SCSR_PART_NTR),
    .wr_en(wr && ques_hit && ques_off == SCSR_PART_EN),
    .wr_data(cmd.data),
    .rd_event(rd && ques_hit && ques_off == SCSR_PART_EVENT),
    .cond_q(qu_cond),
    .ptr_q(qu_ptr),
    .ntr_q(qu_ntr),
    .event_q(qu_ev),
    .en_q(qu_en),
    .sum_q(ques_sum)
  );

  //==============================================================
  // Event status register and its enable
  logic [7:0] esr_q, esr_d, ese_q, ese_d;
  logic esb_q, esb_d; // Event status summary

  // Sticky events; new events win over a clearing read
  always_comb begin
    esr_d = ((rd && cmd.sel == SCSR_SEL_ESR) ? SCSR_ZERO8 : esr_q);
    esr_d = (esr_d | esr_event) & SCSR_ESR_MASK;
    ese_d = (wr && cmd.sel == SCSR_SEL_ESE) ? cmd.data[7:0] : ese_q;
    esb_d = |(esr_d & ese_d);
  end

  // Power-on sets bit seven through the reset value
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      esr_q <= SCSR_ESR_RST;
      ese_q <= SCSR_ZERO8;
      esb_q <= 1'b0;
    end else begin
      esr_q <= esr_d;
      ese_q <= ese_d;
      esb_q <= esb_d;
    end
  end

  //==============================================================
  // Status byte and service request
  logic [7:0] sre_q, sre_d, stb_d;
  logic srq_d;

  // Status byte acts as the top-level condition part
  always_comb begin
    sre_d = (wr && cmd.sel == SCSR_SEL_SRE) ? cmd.data[7:0] : sre_q;
    stb_d = SCSR_ZERO8;
    stb_d[SCSR_STB_ERRQ_BIT] = errq_not_empty;
    stb_d[SCSR_STB_QUES_BIT] = ques_sum;
    stb_d[SCSR_STB_MAV_BIT] = msg_available;
    stb_d[SCSR_STB_ESB_BIT] = esb_q;
    stb_d[SCSR_STB_OPER_BIT] = oper_sum;
    // Summary of the other bits; mask bit six never counts
    stb_d[SCSR_STB_MSS_BIT] = |(stb_d & sre_q & SCSR_SRQ_MASK);
    // Request on an enabled 0 to 1 change of any other bit
    srq_d = |(stb_d & ~stb_q & sre_q & SCSR_SRQ_MASK);
  end

  // Status byte, mask and request flops
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sre_q <= SCSR_ZERO8;
      stb_q <= SCSR_ZERO8;
      srq_q <= 1'b0;
    end else begin
      sre_q <= sre_d;
      stb_q <= stb_d;
      srq_q <= srq_d;
    end
  end

  //==============================================================
  // Read response
  scsr_rsp_t rsp_d;
  logic [15:0] op_part, qu_part; // Selected part of each register

  // Part mux helpers, then the full read mux
  always_comb begin
    case (oper_off)
      SCSR_PART_COND: op_part = op_cond;
      SCSR_PART_PTR: op_part = op_ptr;
      SCSR_PART_NTR: op_part = op_ntr;
      SCSR_PART_EVENT: op_part = op_ev;
      SCSR_PART_EN: op_part = op_en;
      default: op_part = SCSR_ZERO16;
    endcase
    case (ques_off)
      SCSR_PART_COND: qu_part = qu_cond;
      SCSR_PART_PTR: qu_part = qu_ptr;
      SCSR_PART_NTR: qu_part = qu_ntr;
      SCSR_PART_EVENT: qu_part = qu_ev;
      SCSR_PART_EN: qu_part = qu_en;
      default: qu_part = SCSR_ZERO16;
    endcase
    rsp_d.valid = rd;
    rsp_d.data = SCSR_ZERO16;
    // Unmapped selects answer zero
    if (rd) begin
      if (oper_hit && !ques_hit) begin
        rsp_d.data = op_part;
      end else if (ques_hit) begin
        rsp_d.data = qu_part;
      end else begin
        case (cmd.sel)
          SCSR_SEL_STB: rsp_d.data = {8'h00, stb_q};
          SCSR_SEL_SRE: rsp_d.data = {8'h00, sre_q};
          SCSR_SEL_ESR: rsp_d.data = {8'h00, esr_q};
          SCSR_SEL_ESE: rsp_d.data = {8'h00, ese_q};
          default: rsp_d.data = SCSR_ZERO16;
        endcase
      end
    end
  end

  // Response flop, one cycle after the request
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rsp_q <= '0;
    end else begin
      rsp_q <= rsp_d;
    end
  end

  //==============================================================
  // Checks
  a_stb_low_zero: assert property (@(posedge clock) disable iff (!rst_n)
    stb_q[1:0] == 2'b00)
    else $error("Unused status byte bits set");
  a_srq_on_rise: assert property (@(posedge clock) disable iff (!rst_n)
    (|(stb_d & ~stb_q & sre_q & SCSR_SRQ_MASK)) |=> srq_q)
    else $error("Service request missing after enabled rise");
  a_srq_cause: assert property (@(posedge clock) disable iff (!rst_n)
    srq_q |-> (|($past(stb_d) & ~$past(stb_q) & $past(sre_q) & SCSR_SRQ_MASK)))
    else $error("Service request without enabled rise");
  a_mss_summary: assert property (@(posedge clock) disable iff (!rst_n)
    ##1 stb_q[SCSR_STB_MSS_BIT] == (|($past(stb_d) & $past(sre_q) & SCSR_SRQ_MASK)))
    else $error("Bit six does not summarise status byte");
  a_oper_to_stb: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(oper_sum) |=> stb_q[SCSR_STB_OPER_BIT])
    else $error("Operation summary not in status byte");
  a_cal_reaches: assert property (@(posedge clock) disable iff (!rst_n)
    (cal_s2_q && cal_s3_q) |=> ##1 op_cond[SCSR_OPER_CAL_BIT])
    else $error("Calibration not shown in operation condition");
  a_esr_read_clear: assert property (@(posedge clock) disable iff (!rst_n)
    (rd && cmd.sel == SCSR_SEL_ESR && esr_event == SCSR_ZERO8) |=> esr_q == SCSR_ZERO8)
    else $error("Event status not cleared by read");
  // Status byte bits follow their sources one cycle later
  a_errq_to_stb: assert property (@(posedge clock) disable iff (!rst_n)
    ##1 stb_q[SCSR_STB_ERRQ_BIT] == $past(errq_not_empty))
    else $error("Error queue flag not in status byte");
  a_mav_to_stb: assert property (@(posedge clock) disable iff (!rst_n)
    ##1 stb_q[SCSR_STB_MAV_BIT] == $past(msg_available))
    else $error("Message available flag not in status byte");
  a_ques_to_stb: assert property (@(posedge clock) disable iff (!rst_n)
    ##1 stb_q[SCSR_STB_QUES_BIT] == $past(ques_sum))
    else $error("Questionable summary not in status byte");
  a_esb_to_stb: assert property (@(posedge clock) disable iff (!rst_n)
    ##1 stb_q[SCSR_STB_ESB_BIT] == $past(esb_q))
    else $error("Event status summary not in status byte");
  // A new event survives a clearing read in the same cycle
  a_esr_event_set: assert property (@(posedge clock) disable iff (!rst_n)
    (|(esr_event & SCSR_ESR_MASK)) |=>
      ((esr_q & $past(esr_event) & SCSR_ESR_MASK) == ($past(esr_event) & SCSR_ESR_MASK)))
    else $error("Event status bit lost on a clearing read");
  // Condition parts copy live status whatever the port does
  a_cond_follows_live: assert property (@(posedge clock) disable iff (!rst_n)
    ##1 (op_cond == $past(oper_cond_in)) && (qu_cond == $past(filt_q)))
    else $error("Condition part does not follow live status");
  // Command port answers every read on the next edge
  a_rsp_follows_rd: assert property (@(posedge clock) disable iff (!rst_n)
    ##1 rsp_q.valid == $past(rd))
    else $error("Read answer not one cycle after request");
  a_stb_read_data: assert property (@(posedge clock) disable iff (!rst_n)
    (rd && cmd.sel == SCSR_SEL_STB) |=> (rsp_q.data == {8'h00, $past(stb_q)}))
    else $error("Status byte query returned wrong data");
  // Mask writes land on the next edge
  a_srq_mask_write: assert property (@(posedge clock) disable iff (!rst_n)
    (wr && cmd.sel == SCSR_SEL_SRE) |=> (sre_q == $past(cmd.data[7:0])))
    else $error("Service request mask write lost");
  a_esr_mask_write: assert property (@(posedge clock) disable iff (!rst_n)
    (wr && cmd.sel == SCSR_SEL_ESE) |=> (ese_q == $past(cmd.data[7:0])))
    else $error("Event status mask write lost");

endmodule

// ===== logic/scsr_pkg.sv
// Package with constants and carriers for the status reporting block
//==============================================================
// Behaviour
// - Status register has five 16-bit parts
// - One source maps to one bit everywhere
// - Top bit of every part reads zero
// - Operation bit zero shows calibration running
// - Condition follows live status, read-only, unchanged
// - Rising condition sets event if rising filter
// - Falling condition sets event if falling filter
// - Both filters freely read and written
// - Events set only by filtered edges, sticky
// - Event part read-only, read clears it
// - Summary is OR of event AND enable
// - Enable mask freely read and written
// - Summary drives condition bit one level up
// - Service mask masks byte, event mask masks ESR
// - Status byte bit six summarises others
// - Service mask bit six is ignored
// - Enabled status byte rising raises service request
// - Status byte bit two flags errors queued
// - Status byte bit three is questionable summary
// - Status byte bit four flags message available
// - Status byte bit five is event status summary
// - Status byte bit seven is operation summary
// - Event status bit seven set at power on
package scsr_pkg;

  //==============================================================
  // Widths and masks
  localparam int SCSR_REG_W = 16;
  localparam int SCSR_BYTE_W = 8;
  localparam logic [15:0] SCSR_VALID_MASK = 16'h7FFF;
  localparam logic [15:0] SCSR_PTR_RST = 16'h7FFF;
  localparam logic [15:0] SCSR_ZERO16 = 16'h0000;
  localparam logic [7:0] SCSR_ESR_MASK = 8'hBD;
  localparam logic [7:0] SCSR_ESR_RST = 8'h80;
  localparam logic [7:0] SCSR_SRQ_MASK = 8'hBF;
  localparam logic [7:0] SCSR_ZERO8 = 8'h00;

  //==============================================================
  // Bit positions
  localparam int SCSR_OPER_CAL_BIT = 0;
  localparam int SCSR_STB_ERRQ_BIT = 2;
  localparam int SCSR_STB_QUES_BIT = 3;
  localparam int SCSR_STB_MAV_BIT = 4;
  localparam int SCSR_STB_ESB_BIT = 5;
  localparam int SCSR_STB_MSS_BIT = 6;
  localparam int SCSR_STB_OPER_BIT = 7;

  //==============================================================
  // Command port register selects
  localparam logic [3:0] SCSR_SEL_STB = 4'h0;
  localparam logic [3:0] SCSR_SEL_SRE = 4'h1;
  localparam logic [3:0] SCSR_SEL_ESR = 4'h2;
  localparam logic [3:0] SCSR_SEL_ESE = 4'h3;
  localparam logic [3:0] SCSR_SEL_OPER = 4'h4;
  localparam logic [3:0] SCSR_SEL_QUES = 4'h9;
  // Part offsets added to a register's base select
  localparam logic [3:0] SCSR_PART_COND = 4'h0;
  localparam logic [3:0] SCSR_PART_PTR = 4'h1;
  localparam logic [3:0] SCSR_PART_NTR = 4'h2;
  localparam logic [3:0] SCSR_PART_EVENT = 4'h3;
  localparam logic [3:0] SCSR_PART_EN = 4'h4;

  //==============================================================
  // Carriers
  typedef struct packed {
    logic valid;
    logic write;
    logic [3:0] sel;
    logic [15:0] data;
  } scsr_cmd_t;

  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } scsr_rsp_t;

endpackage

// ===== logic/scsr_status_reg.sv
// One five-part status register with edge filters and summary bit
`timescale 1ns/10ps
module scsr_status_reg import scsr_pkg::*; (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Live condition and part access strobes
  input wire logic [15:0] cond_in,
  input wire logic wr_ptr,
  input wire logic wr_ntr,
  input wire logic wr_en,
  input wire logic [15:0] wr_data,
  input wire logic rd_event,
  // Part contents and summary
  output logic [15:0] cond_q,
  output logic [15:0] ptr_q,
  output logic [15:0] ntr_q,
  output logic [15:0] event_q,
  output logic [15:0] en_q,
  output logic sum_q
);

  logic [15:0] cond_d, ptr_d, ntr_d, event_d, en_d;
  logic [15:0] rise, fall; // Filtered edges this cycle
  logic sum_d;

  // Next values of all five parts
  always_comb begin
    cond_d = cond_in & SCSR_VALID_MASK;
    ptr_d = wr_ptr ? (wr_data & SCSR_VALID_MASK) : ptr_q;
    ntr_d = wr_ntr ? (wr_data & SCSR_VALID_MASK) : ntr_q;
    en_d = wr_en ? (wr_data & SCSR_VALID_MASK) : en_q;
    rise = cond_d & ~cond_q & ptr_q;
    fall = ~cond_d & cond_q & ntr_q;
    // Clear by read first, then OR in new edges so they survive
    event_d = ((rd_event ? SCSR_ZERO16 : event_q) | rise | fall) & SCSR_VALID_MASK;
    sum_d = |(event_d & en_d);
  end

  // Registers; reset leaves rising filter open, others shut
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cond_q <= SCSR_ZERO16;
      ptr_q <= SCSR_PTR_RST;
      ntr_q <= SCSR_ZERO16;
      event_q <= SCSR_ZERO16;
      en_q <= SCSR_ZERO16;
      sum_q <= 1'b0;
    end else begin
      cond_q <= cond_d;
      ptr_q <= ptr_d;
      ntr_q <= ntr_d;
      event_q <= event_d;
      en_q <= en_d;
      sum_q <= sum_d;
    end
  end

  a_rise_sets_event: assert property (@(posedge clock) disable iff (!rst_n)
    (|(cond_d & ~cond_q & ptr_q)) |=> (|event_q))
    else $error("Filtered rising edge did not set event");
  a_read_clears: assert property (@(posedge clock) disable iff (!rst_n)
    (rd_event && cond_d == cond_q) |=> (event_q == SCSR_ZERO16))
    else $error("Event part not cleared by read");
  a_top_bit_zero: assert property (@(posedge clock) disable iff (!rst_n)
    !(cond_q[15] | ptr_q[15] | ntr_q[15] | event_q[15] | en_q[15]))
    else $error("Top bit of a part is set");
  a_sum_matches: assert property (@(posedge clock) disable iff (!rst_n)
    ##1 sum_q == (|(event_q & en_q)))
    else $error("Summary does not match event and enable");

endmodule

// ===== bench/scsr_ctrl_model.sv
// Remote controller model that issues commands to the status reporting block
`timescale 1ns/10ps
module scsr_ctrl_model import scsr_pkg::*; (
  // Clock
  input wire logic clock,
  // Command port
  output scsr_cmd_t cmd,
  input wire scsr_rsp_t rsp_q
);
  int timeouts = 0; // Reads that got no answer in time

  initial begin
    cmd = '0;
  end

  //==============================================================
  // Write: one-cycle request, no answer comes back
  task automatic wr(input logic [3:0] sel, input logic [15:0] data);
    @(negedge clock);
    cmd = '{valid: 1'b1, write: 1'b1, sel: sel, data: data};
    @(negedge clock);
    // Released data shows the inverse so a stale value cannot pass
    cmd = '{valid: 1'b0, write: 1'b0, sel: ~sel, data: ~data};
  endtask

  //==============================================================
  // Read: the status byte is fetched by query like any select
  task automatic rd(input logic [3:0] sel, output logic [15:0] data);
    int n;
    @(negedge clock);
    cmd = '{valid: 1'b1, write: 1'b0, sel: sel, data: 16'hA5A5};
    @(negedge clock);
    cmd = '{valid: 1'b0, write: 1'b1, sel: ~sel, data: 16'h5A5A};
    data = 16'hFFFF;
    // Bounded wait for the answer pulse
    for (n = 0; n < 4 && rsp_q.valid !== 1'b1; n++) @(negedge clock);
    if (rsp_q.valid === 1'b1) begin
      data = rsp_q.data;
    end else begin
      timeouts++;
    end
  endtask
endmodule

// ===== bench/tb_top.sv
// Self-checking bench for the status reporting hierarchy
`timescale 1ns/10ps
module tb_top import scsr_pkg::*;;
  //==============================================================
  // Design signals
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic calibrating = 1'b0;
  logic [14:0] ques_cond = 15'h0000;
  logic errq_not_empty = 1'b0;
  logic msg_available = 1'b0;
  logic [7:0] esr_event = 8'h00;
  scsr_cmd_t cmd;
  scsr_rsp_t rsp_q;
  logic [7:0] stb_q;
  logic srq_q;
  // Bench bookkeeping
  int mismatches = 0;
  int check_count = 0;
  int seed = 32'h226B60AB;
  int srq_n = 0;
  int base;
  // Reference model: index 0 operation, 1 questionable
  logic [15:0] m_ptr [2];
  logic [15:0] m_ntr [2];
  logic [15:0] m_en [2];
  logic [15:0] m_ev [2];
  logic [7:0] m_sre, m_ese, m_esr;
  logic [15:0] d, old;
  logic [3:0] rw_sel [8] = '{4'h5, 4'h6, 4'h8, 4'hA, 4'hB, 4'hD, 4'h1, 4'h3};
  logic [3:0] ro_sel [7] = '{4'h0, 4'h2, 4'h4, 4'h7, 4'h9, 4'hC, 4'hE};

  always #50 clock = ~clock;

  // Service request pulses, counted per cycle
  always @(posedge clock) begin
    if (srq_q === 1'b1) srq_n <= srq_n + 1;
  end

  scsr_status_top dut_u (.clock(clock), .rst_n(rst_n), .calibrating(calibrating),
    .ques_cond(ques_cond), .errq_not_empty(errq_not_empty), .msg_available(msg_available),
    .esr_event(esr_event), .cmd(cmd), .rsp_q(rsp_q), .stb_q(stb_q), .srq_q(srq_q));

  scsr_ctrl_model u_ctrl (.clock(clock), .cmd(cmd), .rsp_q(rsp_q));

  //==============================================================
  // Shared helpers
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic rd_chk(input string what, input logic [3:0] sel, input logic [15:0] exp);
    logic [15:0] v;
    u_ctrl.rd(sel, v);
    check(what, v, exp);
  endtask

  // Status byte worked out from the model
  function automatic logic [15:0] exp_stb();
    logic [7:0] b;
    b = 8'h00;
    b[2] = errq_not_empty;
    b[3] = |(m_ev[1] & m_en[1]);
    b[4] = msg_available;
    b[5] = |(m_esr & m_ese);
    b[7] = |(m_ev[0] & m_en[0]);
    b[6] = |(b & m_sre & SCSR_SRQ_MASK);
    return {8'h00, b};
  endfunction

  // Write a read-write part and mirror it in the model
  task automatic wr_part(input logic [3:0] sel, input logic [15:0] v);
    case (sel)
      4'h5: m_ptr[0] = v;
      4'h6: m_ntr[0] = v;
      4'h8: m_en[0] = v;
      4'hA: m_ptr[1] = v;
      4'hB: m_ntr[1] = v;
      4'hD: m_en[1] = v;
      4'h1: m_sre = v[7:0];
      default: m_ese = v[7:0];
    endcase
    u_ctrl.wr(sel, v);
  endtask

  // Filtered edges into the event part
  task automatic edge_in(input int r, input logic [15:0] o, input logic [15:0] n);
    m_ev[r] = m_ev[r] | (~o & n & m_ptr[r]) | (o & ~n & m_ntr[r]);
  endtask

  task automatic conclude();
    mismatches += u_ctrl.timeouts;
    $display("Checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge clock);
    mismatches++;
    conclude();
  end

  //==============================================================
  // Main sequence
  initial begin
    m_ptr = '{16'h7FFF, 16'h7FFF};
    m_ntr = '{16'h0000, 16'h0000};
    m_en = '{16'h0000, 16'h0000};
    m_ev = '{16'h0000, 16'h0000};
    m_sre = 8'h00;
    m_ese = 8'h00;
    m_esr = 8'h80;
    repeat (12) @(posedge clock);
    @(negedge clock);
    rst_n = 1'b1;
    // Reset values, then random writes read back twice
    for (int i = 0; i < 8; i++) begin
      rd_chk("reset part", rw_sel[i], (i == 0 || i == 3) ? 16'h7FFF : 16'h0000);
      d = 16'($random(seed));
      d = (i == 7) ? (d & 16'h00BD) : (i == 6) ? (d & 16'h00FF) : (d & 16'h7FFF);
      // Sixteen-bit parts get bit 15 set on write; it must read back zero
      wr_part(rw_sel[i], (i < 6) ? (d | 16'h8000) : d);
      rd_chk("rw part", rw_sel[i], d);
      rd_chk("rw again", rw_sel[i], d);
    end
    // Writes to read-only and unmapped places change nothing
    for (int i = 0; i < 7; i++) u_ctrl.wr(ro_sel[i], 16'h7FFF);
    rd_chk("power on", 4'h2, 16'h0080);
    m_esr = 8'h00;
    rd_chk("esr cleared", 4'h2, 16'h0000);
    for (int i = 2; i < 7; i++) rd_chk("read only", ro_sel[i], 16'h0000);
    rd_chk("stb query", 4'h0, exp_stb());
    $display("test reset_rw done");
    // Questionable edges through random filters
    for (int i = 0; i < 6; i++) begin
      wr_part(4'hA, 16'($random(seed)) & 16'h7FFF);
      wr_part(4'hB, 16'($random(seed)) & 16'h7FFF);
      wr_part(4'hD, 16'($random(seed)) & 16'h7FFF);
      old = {1'b0, ques_cond};
      d = 16'($random(seed)) & 16'h7FFF;
      edge_in(1, old, d);
      ques_cond = d[14:0];
      repeat (8) @(negedge clock);
      check("stb ques", {8'h00, stb_q}, exp_stb());
      rd_chk("stb query", 4'h0, exp_stb());
      rd_chk("ques cond", 4'h9, d);
      rd_chk("ques event", 4'hC, m_ev[1]);
      m_ev[1] = 16'h0000;
      rd_chk("ques clear", 4'hC, 16'h0000);
    end
    $display("test ques_edges done");
    // Calibration, error queue and message bits with service request
    wr_part(4'hD, 16'h0000);
    wr_part(4'h1, 16'h00C4);
    wr_part(4'h5, 16'h7FFF);
    wr_part(4'h6, 16'h0001);
    wr_part(4'h8, 16'h0001);
    base = srq_n;
    calibrating = 1'b1;
    edge_in(0, 16'h0000, 16'h0001);
    repeat (8) @(negedge clock);
    check("stb oper", {8'h00, stb_q}, exp_stb());
    check("srq oper", 16'(srq_n - base), 16'h0001);
    errq_not_empty = 1'b1;
    repeat (8) @(negedge clock);
    check("srq errq", 16'(srq_n - base), 16'h0002);
    msg_available = 1'b1;
    calibrating = 1'b0;
    edge_in(0, 16'h0001, 16'h0000);
    repeat (8) @(negedge clock);
    check("stb msg", {8'h00, stb_q}, exp_stb());
    rd_chk("oper cond", 4'h4, 16'h0000);
    rd_chk("oper event", 4'h7, m_ev[0]);
    m_ev[0] = 16'h0000;
    // Event status bit through its own mask
    wr_part(4'h3, 16'h0020);
    esr_event = 8'h20;
    @(negedge clock);
    esr_event = 8'h00;
    m_esr = 8'h20;
    repeat (6) @(negedge clock);
    check("stb esb", {8'h00, stb_q}, exp_stb());
    rd_chk("esr read", 4'h2, 16'h0020);
    m_esr = 8'h00;
    repeat (6) @(negedge clock);
    check("stb final", {8'h00, stb_q}, exp_stb());
    check("srq final", 16'(srq_n - base), 16'h0002);
    $display("test srq_chain done");
    conclude();
  end
endmodule
